// file: rtl/sba_regs.svh
// Purpose: offsets, field positions, reset values and counts of the arbiter counter
// Assumes: AXI4-Lite byte addresses, 8-bit address
// Notes:   definitions only
`ifndef SBA_REGS_SVH
`define SBA_REGS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SBA_CTRL_OFS   8'h00
`define SBA_COUNT_OFS  8'h04
`define SBA_STAT_OFS   8'h08
`define SBA_MASK_OFS   8'h0c
`define SBA_CFG_OFS    8'h10
// ---------------------------------------------------------------
// control and config register fields
// ---------------------------------------------------------------
`define SBA_MODE_HI    7
`define SBA_MODE_LO    6
`define SBA_LOST       5
`define SBA_CLKSEL     4
`define SBA_DONE       3
`define SBA_RUN        2
`define SBA_OVF        1
`define SBA_TOP        0
`define SBA_CFG_SRC    0
// status and mask bits
`define SBA_EV_DONE    0
`define SBA_EV_LOST    1
`define SBA_EV_OVF     2
// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define SBA_CTRL_RST   2'h0
`define SBA_EV_RST     3'h0
`define SBA_SAMPLE_BUS 9'h038
`define SBA_SAMPLE_PSC 9'h008
`define SBA_CNT_MAX    9'h1ff
`define SBA_DIV_LAST   2'h3
`define SBA_RESP_OK    2'h0
`define SBA_RESP_ERR   2'h2
`endif

// file: rtl/sba_pkg.sv
// Purpose: types of the arbiter counter
// Assumes: nothing
// Notes:   constants live in sba_regs.svh
package sba_pkg;
  typedef enum logic [1:0] {
    SBA_M_IDLE = 2'h0,
    SBA_M_MEAS = 2'h1,
    SBA_M_ARB  = 2'h2,
    SBA_M_RSVD = 2'h3
  } sba_mode_t;

  typedef enum logic [3:0] {
    SBA_ST_IDLE = 4'h1,
    SBA_ST_WAIT = 4'h2,
    SBA_ST_RUN  = 4'h4,
    SBA_ST_DONE = 4'h8
  } sba_state_t;

  typedef struct packed {
    logic ovf;
    logic lost;
    logic done;
  } sba_flags_t;
endpackage : sba_pkg

// file: rtl/sba_arbiter.sv
// Purpose: bus arbiter / bit time counter with AXI4-Lite registers
// Assumes: one clock aclk at 20 MHz, prescaler ticks from the serial core
// Notes:
// Functional notes
// - nine-bit counter plus one overflow bit
// - mode field selects idle, measure, arbitrate
// - mode 00 resets and holds counter idle
// - lost flag cleared by writing zero high
// - clock select: prescaler half or bus/4
// - prescaler source bus or quad clock
// - done flag set at end; write clears
// - running flag shows counter counting
// - overflow flag set on wrap; write clears
// - counter top bit readable; write clears
// - low byte readable; write clears (here writes to the count offset are ignored, a control write clears it)
// - bus clock: falling edge to falling edge
// - prescaler clock: low level to rising edge
// - arbitration samples rx, loss forces tx high
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sba_regs.svh"
module sba_arbiter (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_pin,
  input  wire logic        shift_register_output,
  input  wire logic        presc_bus_tick,
  input  wire logic        presc_quad_tick,
  output logic             tx_pin,
  output logic             irq
);
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic sba_hit(input logic [7:0] a, input logic [7:0] ofs);
    sba_hit = (a == ofs);
  endfunction : sba_hit

  function automatic logic sba_mapped(input logic [7:0] a);
    sba_mapped = sba_hit(a, `SBA_CTRL_OFS) | sba_hit(a, `SBA_COUNT_OFS) |
                 sba_hit(a, `SBA_STAT_OFS) | sba_hit(a, `SBA_MASK_OFS) |
                 sba_hit(a, `SBA_CFG_OFS);
  endfunction : sba_mapped

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic               aw_full, next_aw_full;
  logic [7:0]         aw_addr, next_aw_addr;
  logic               w_full, next_w_full;
  logic [31:0]        w_data, next_w_data;
  logic               w_lane, next_w_lane;
  logic               bvalid, next_bvalid;
  logic [1:0]         bresp, next_bresp;
  logic               rvalid, next_rvalid;
  logic [31:0]        rdata, next_rdata;
  logic [1:0]         rresp, next_rresp;
  sba_pkg::sba_mode_t mode, next_mode;
  logic               clk_sel, next_clk_sel;
  logic               presc_src, next_presc_src;
  logic [2:0]         ev_stat, next_ev_stat;
  logic [2:0]         ev_mask, next_ev_mask;
  sba_pkg::sba_state_t state, next_state;
  logic [8:0]         count, next_count;
  sba_pkg::sba_flags_t flags, next_flags;
  sba_pkg::sba_flags_t set_f;
  logic [2:0]         rx_s, next_rx_s;
  logic               rx_lvl, next_rx_lvl;
  logic               tx_prev, next_tx_prev;
  logic [1:0]         div_cnt, next_div_cnt;
  logic               half_ph, next_half_ph;
  logic               next_tx_pin;
  logic               do_write, wr_ctrl, presc_in, div_tick, tick;
  logic               rx_fall, rx_rise, tx_rise, tx_fall;
  logic [8:0]         sample_at;
  logic [7:0]         ctrl_rd;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_full && !bvalid;
  assign s_axi_wready  = !w_full && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign do_write = aw_full && w_full && !bvalid;
  assign wr_ctrl  = do_write && w_lane && sba_hit(aw_addr, `SBA_CTRL_OFS);
  assign ctrl_rd  = {mode, flags.lost, clk_sel, flags.done,
                     state == sba_pkg::SBA_ST_RUN, flags.ovf, count[8]};

  always_comb
  begin
    next_aw_full   = aw_full;
    next_aw_addr   = aw_addr;
    next_w_full    = w_full;
    next_w_data    = w_data;
    next_w_lane    = w_lane;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_rvalid    = rvalid;
    next_rdata     = rdata;
    next_rresp     = rresp;
    next_mode      = mode;
    next_clk_sel   = clk_sel;
    next_presc_src = presc_src;
    next_ev_mask   = ev_mask;
    // sticky events, a new event beats a clearing write
    next_ev_stat   = ev_stat | {set_f.ovf, set_f.lost, set_f.done};
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_lane = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = sba_mapped(aw_addr) ? `SBA_RESP_OK : `SBA_RESP_ERR;
      if (w_lane)
      begin
        if (sba_hit(aw_addr, `SBA_CTRL_OFS))
        begin
          next_mode    = sba_pkg::sba_mode_t'(w_data[`SBA_MODE_HI:`SBA_MODE_LO]);
          next_clk_sel = w_data[`SBA_CLKSEL];
        end
        if (sba_hit(aw_addr, `SBA_STAT_OFS))
          next_ev_stat = (ev_stat & ~w_data[2:0]) | {set_f.ovf, set_f.lost, set_f.done};
        if (sba_hit(aw_addr, `SBA_MASK_OFS))
          next_ev_mask = w_data[2:0];
        if (sba_hit(aw_addr, `SBA_CFG_OFS))
          next_presc_src = w_data[`SBA_CFG_SRC];
      end
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = sba_mapped(s_axi_araddr) ? `SBA_RESP_OK : `SBA_RESP_ERR;
      next_rdata  = 32'h0000_0000;
      if (sba_hit(s_axi_araddr, `SBA_CTRL_OFS))
        next_rdata[7:0] = ctrl_rd;
      if (sba_hit(s_axi_araddr, `SBA_COUNT_OFS))
        next_rdata[7:0] = count[7:0];
      if (sba_hit(s_axi_araddr, `SBA_STAT_OFS))
        next_rdata[2:0] = ev_stat;
      if (sba_hit(s_axi_araddr, `SBA_MASK_OFS))
        next_rdata[2:0] = ev_mask;
      if (sba_hit(s_axi_araddr, `SBA_CFG_OFS))
        next_rdata[0] = presc_src;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full   <= 1'b0;
      aw_addr   <= 8'h00;
      w_full    <= 1'b0;
      w_data    <= 32'h0000_0000;
      w_lane    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `SBA_RESP_OK;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= `SBA_RESP_OK;
      mode      <= sba_pkg::sba_mode_t'(`SBA_CTRL_RST);
      clk_sel   <= 1'b0;
      presc_src <= 1'b0;
      ev_stat   <= `SBA_EV_RST;
      ev_mask   <= `SBA_EV_RST;
    end
    else
    begin
      aw_full   <= next_aw_full;
      aw_addr   <= next_aw_addr;
      w_full    <= next_w_full;
      w_data    <= next_w_data;
      w_lane    <= next_w_lane;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
      mode      <= next_mode;
      clk_sel   <= next_clk_sel;
      presc_src <= next_presc_src;
      ev_stat   <= next_ev_stat;
      ev_mask   <= next_ev_mask;
    end
  end

  assign irq = |(ev_stat & ev_mask);

  // ---------------------------------------------------------------
  // counter core
  // ---------------------------------------------------------------
  assign presc_in  = presc_src ? presc_quad_tick : presc_bus_tick;
  assign div_tick  = (div_cnt == `SBA_DIV_LAST);
  assign tick      = clk_sel ? (presc_in && half_ph) : div_tick;
  assign rx_fall   = rx_lvl && (rx_s[1] == rx_s[2]) && !rx_s[2];
  assign rx_rise   = !rx_lvl && (rx_s[1] == rx_s[2]) && rx_s[2];
  assign tx_rise   = shift_register_output && !tx_prev;
  assign tx_fall   = !shift_register_output && tx_prev;
  assign sample_at = clk_sel ? `SBA_SAMPLE_PSC : `SBA_SAMPLE_BUS;

  always_comb
  begin
    next_rx_s    = {rx_s[1:0], rx_pin};
    next_rx_lvl  = (rx_s[1] == rx_s[2]) ? rx_s[2] : rx_lvl;
    next_tx_prev = shift_register_output;
    next_div_cnt = div_cnt + 2'h1;
    next_half_ph = presc_in ? !half_ph : half_ph;
    next_state   = state;
    next_count   = count;
    set_f        = '0;
    case (state)
      sba_pkg::SBA_ST_IDLE:
        next_state = sba_pkg::SBA_ST_WAIT;
      sba_pkg::SBA_ST_WAIT:
        if ((mode == sba_pkg::SBA_M_MEAS && !clk_sel && rx_fall) ||
            (mode == sba_pkg::SBA_M_MEAS && clk_sel && !rx_lvl) ||
            (mode == sba_pkg::SBA_M_ARB && tx_rise))
        begin
          next_state = sba_pkg::SBA_ST_RUN;
          next_count = 9'h000;
        end
      sba_pkg::SBA_ST_RUN:
      begin
        if (tick)
        begin
          next_count = count + 9'h001;
          set_f.ovf  = (count == `SBA_CNT_MAX);
          if (mode == sba_pkg::SBA_M_ARB && count == sample_at && !rx_lvl)
            set_f.lost = 1'b1;
        end
        if (mode == sba_pkg::SBA_M_MEAS && ((!clk_sel && rx_fall) || (clk_sel && rx_rise)))
        begin
          next_state = sba_pkg::SBA_ST_DONE;
          next_count = count;
          set_f.ovf  = 1'b0;
          set_f.done = 1'b1;
        end
        if (mode == sba_pkg::SBA_M_ARB && tx_rise)
          next_count = 9'h000;
        else if (mode == sba_pkg::SBA_M_ARB && tx_fall && !flags.lost && !set_f.lost)
        begin
          next_state = sba_pkg::SBA_ST_WAIT;
          next_count = 9'h000;
        end
      end
      sba_pkg::SBA_ST_DONE:
        next_state = sba_pkg::SBA_ST_DONE;
      default:
        next_state = sba_pkg::SBA_ST_IDLE;
    endcase
    if (wr_ctrl)
    begin
      // a control write clears the count and rearms the chosen mode
      next_count = 9'h000;
      next_state = sba_pkg::SBA_ST_IDLE;
    end
    if (mode == sba_pkg::SBA_M_IDLE || mode == sba_pkg::SBA_M_RSVD)
    begin
      next_state = sba_pkg::SBA_ST_IDLE;
      next_count = 9'h000;
      set_f      = '0;
    end
    next_flags.done = set_f.done | (flags.done & !wr_ctrl);
    next_flags.ovf  = set_f.ovf | (flags.ovf & !wr_ctrl);
    next_flags.lost = set_f.lost |
                      (flags.lost & !(wr_ctrl && !w_data[`SBA_MODE_HI]));
    next_tx_pin = shift_register_output | next_flags.lost;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_s    <= 3'h7;
      rx_lvl  <= 1'b1;
      tx_prev <= 1'b1;
      div_cnt <= 2'h0;
      half_ph <= 1'b0;
      state   <= sba_pkg::SBA_ST_IDLE;
      count   <= 9'h000;
      flags   <= '0;
      tx_pin  <= 1'b1;
    end
    else
    begin
      rx_s    <= next_rx_s;
      rx_lvl  <= next_rx_lvl;
      tx_prev <= next_tx_prev;
      div_cnt <= next_div_cnt;
      half_ph <= next_half_ph;
      state   <= next_state;
      count   <= next_count;
      flags   <= next_flags;
      tx_pin  <= next_tx_pin;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence div_period_s;
    !div_tick [*3] ##1 div_tick;
  endsequence

  idle_hold_a: assert property ((mode == sba_pkg::SBA_M_IDLE) |=> count == 9'h000)
    else $error("counter not held in idle");
  rsvd_idle_a: assert property ((mode == sba_pkg::SBA_M_RSVD) |=> state == sba_pkg::SBA_ST_IDLE && !set_f.done)
    else $error("reserved mode not idle");
  div_four_a: assert property (div_tick |=> div_period_s)
    else $error("bus divider not by four");
  lost_clear_a: assert property ((wr_ctrl && !w_data[`SBA_MODE_HI] && !set_f.lost) |=> !flags.lost)
    else $error("lost flag not cleared");
  wr_clear_a: assert property ((wr_ctrl && !set_f.ovf && !set_f.done) |=> !flags.ovf && !flags.done && count == 9'h000)
    else $error("control write did not clear");
  done_set_a: assert property ((set_f.done && !wr_ctrl) |=>
    flags.done && state == sba_pkg::SBA_ST_DONE)
    else $error("done flag not set at stop");
  meas_start_a: assert property ((state == sba_pkg::SBA_ST_WAIT && mode == sba_pkg::SBA_M_MEAS && clk_sel && !rx_lvl && !wr_ctrl) |=> ctrl_rd[`SBA_RUN])
    else $error("immediate start missing");
  lost_set_a: assert property ((state == sba_pkg::SBA_ST_RUN && mode == sba_pkg::SBA_M_ARB && tick && !clk_sel && count == 9'h038 && !rx_lvl) |=> flags.lost ##1 tx_pin)
    else $error("arbitration loss not seen");
  wrap_a: assert property ((state == sba_pkg::SBA_ST_RUN && tick && count == 9'h1ff && next_state == sba_pkg::SBA_ST_RUN && !wr_ctrl) |=> count == 9'h000 && flags.ovf)
    else $error("wrap without overflow");
endmodule : sba_arbiter
`default_nettype wire

// file: verification/sba_bus_node.sv
// Purpose: other node on the serial bus plus the serial prescaler
// Assumes: wired-and bus line held high by a pull-up
// Notes:   tick periods are parameters
`timescale 1ns/1ps
`default_nettype none
module sba_bus_node #(
  parameter int BUS_DIV  = 8,
  parameter int QUAD_DIV = 2
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tx_pin,
  input  wire logic dominant,
  output logic      rx_pin,
  output logic      tick_bus,
  output logic      tick_quad
);
  int n_bus;
  int n_quad;
  // any node pulling low wins the line
  assign rx_pin = tx_pin & ~dominant;
  // one-cycle prescaler pulses from bus or quad source
  always_ff @(posedge aclk)
  begin
    n_bus     <= (!aresetn || n_bus == BUS_DIV - 1) ? 0 : n_bus + 1;
    n_quad    <= (!aresetn || n_quad == QUAD_DIV - 1) ? 0 : n_quad + 1;
    tick_bus  <= aresetn && n_bus == BUS_DIV - 1;
    tick_quad <= aresetn && n_quad == QUAD_DIV - 1;
  end
endmodule : sba_bus_node
`default_nettype wire

// file: verification/sba_arbiter_tb.sv
// Purpose: self-checking bench of the arbiter counter
// Assumes: partner node drives the receive line and prescaler ticks
// Notes:   measured counts compared with small slack
`timescale 1ns/1ps
`default_nettype none
`include "sba_regs.svh"
module sba_arbiter_tb;
  localparam int PB = 8;
  localparam int PQ = 2;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx, srout, tick_b, tick_q, tx, irq, dom;
  logic [7:0]  awaddr, araddr, m_mode;
  logic [31:0] wdata, rdata, rdat, rsp, lfsr, m_stat, m_mask;
  logic [1:0]  bresp, rresp;
  bit          m_ovf, m_done, m_lost;
  int          m_cnt, n_mismatch, n_checks;
  int          q_gap[$];

  sba_arbiter i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_pin(rx),
    .shift_register_output(srout), .presc_bus_tick(tick_b), .presc_quad_tick(tick_q),
    .tx_pin(tx), .irq(irq)
  );
  sba_bus_node #(.BUS_DIV(PB), .QUAD_DIV(PQ)) i_node (
    .aclk(aclk), .aresetn(aresetn), .tx_pin(tx), .dominant(dom), .rx_pin(rx),
    .tick_bus(tick_b), .tick_quad(tick_q)
  );

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  function automatic logic [31:0] m_ctrl(input logic run);
    m_ctrl = {24'h0, m_mode[7:6], m_lost, m_mode[4], m_done, run, m_ovf, m_cnt[8]};
  endfunction : m_ctrl

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic near(input logic [31:0] got, input int exp, input int tol);
    n_checks++;
    if ($isunknown(got) || int'(got) - exp > tol || exp - int'(got) > tol)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : near

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta;
    bit tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      awvalid <= !ta;
      wvalid  <= !tw;
    end
    do @(posedge aclk); while (!bvalid);
    rsp = 32'(bresp);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rdat = rdata;
    rsp  = 32'(rresp);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic wctl(input logic [7:0] v);
    wr(`SBA_CTRL_OFS, {24'h0, v});
    m_mode = v & 8'hd0;
    m_cnt  = 0;
    m_done = 1'b0;
    m_ovf  = 1'b0;
    m_lost = m_lost & v[7];
  endtask : wctl

  // two falling edges gap cycles apart, running flag looked at between when mid is set
  task automatic pair(input int gap, input bit mid);
    dom <= 1'b1;
    repeat (20) @(posedge aclk);
    dom <= 1'b0;
    rd(`SBA_CTRL_OFS);
    if (mid)
      chk(rdat, m_ctrl(1'b1));
    repeat (gap - 23) @(posedge aclk);
    dom <= 1'b1;
    repeat (20) @(posedge aclk);
    dom <= 1'b0;
    repeat (20) @(posedge aclk);
  endtask : pair

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready, dom} = '0;
    {m_mode, m_cnt, m_ovf, m_done, m_lost, m_stat, m_mask} = '0;
    srout = 1'b1;
    aresetn = 1'b0;
    lfsr = 32'h1504cfa0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a <= 16; a += 4)
    begin
      rd(8'(a));
      chk(rdat, 32'h0);
      chk(rsp, 32'(`SBA_RESP_OK));
    end
    rd(8'h14);
    chk(rsp, 32'(`SBA_RESP_ERR));
    wr(`SBA_COUNT_OFS, 32'hff);
    chk(rsp, 32'(`SBA_RESP_OK));
    wr(8'h14, 32'h0);
    chk(rsp, 32'(`SBA_RESP_ERR));
    rd(`SBA_COUNT_OFS);
    chk(rdat, 32'h0);
    $display("test registers done");
    q_gap = '{1200, 2600};
    repeat (3)
    begin
      lfsr = nxt(lfsr);
      q_gap.push_back(100 + int'(lfsr % 800));
    end
    while (q_gap.size() > 0)
    begin
      wctl(8'h40);
      pair(q_gap[0], 1'b1);
      m_cnt  = q_gap.pop_front() / 4;
      m_ovf  = m_cnt > 511;
      m_cnt  = m_cnt % 512;
      m_done = 1'b1;
      m_stat[`SBA_EV_DONE] = 1'b1;
      m_stat[`SBA_EV_OVF] = m_stat[`SBA_EV_OVF] | m_ovf;
      rd(`SBA_CTRL_OFS);
      chk(rdat, m_ctrl(1'b0));
      rd(`SBA_COUNT_OFS);
      near(rdat, m_cnt % 256, 1);
    end
    $display("test bus clock measurement done");
    for (int s = 0; s < 2; s++)
    begin
      wr(`SBA_CFG_OFS, 32'(s));
      dom <= 1'b1;
      repeat (20) @(posedge aclk);
      wctl(8'h50);
      repeat (400) @(posedge aclk);
      dom <= 1'b0;
      repeat (20) @(posedge aclk);
      m_cnt  = 400 / (2 * (s ? PQ : PB));
      m_done = 1'b1;
      rd(`SBA_CTRL_OFS);
      chk(rdat, m_ctrl(1'b0));
      rd(`SBA_COUNT_OFS);
      near(rdat, m_cnt, 2);
    end
    $display("test prescaler measurement done");
    for (int k = 0; k < 2; k++)
    begin
      wctl(8'h80 | 8'(k << 4));
      dom   <= 1'b1;
      srout <= 1'b0;
      @(posedge aclk);
      srout <= 1'b1;
      repeat (300) @(posedge aclk);
      srout <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(32'(tx), 32'h1);
      m_lost = 1'b1;
      m_stat[`SBA_EV_LOST] = 1'b1;
      rd(`SBA_CTRL_OFS);
      chk(rdat | 32'h4, m_ctrl(1'b1));
      wctl(m_mode);
      rd(`SBA_CTRL_OFS);
      chk(rdat | 32'h4, m_ctrl(1'b1));
      wctl(8'h00);
      dom <= 1'b0;
      rd(`SBA_CTRL_OFS);
      chk(rdat, m_ctrl(1'b0));
    end
    wctl(8'h80);
    srout <= 1'b0;
    @(posedge aclk);
    srout <= 1'b1;
    repeat (300) @(posedge aclk);
    srout <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(tx), 32'h0);
    rd(`SBA_CTRL_OFS);
    chk(rdat | 32'h4, m_ctrl(1'b1));
    $display("test arbitration done");
    wctl(8'hc0);
    pair(200, 1'b0);
    rd(`SBA_CTRL_OFS);
    chk(rdat, m_ctrl(1'b0));
    rd(`SBA_COUNT_OFS);
    chk(rdat, 32'h0);
    $display("test reserved mode done");
    wctl(8'h00);
    rd(`SBA_STAT_OFS);
    chk(rdat, m_stat);
    chk(32'(irq), 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      m_mask = 32'h1 << i;
      wr(`SBA_MASK_OFS, m_mask);
      chk(32'(irq), 32'(|(m_stat & m_mask)));
      wr(`SBA_STAT_OFS, m_mask);
      m_stat[i] = 1'b0;
      chk(32'(irq), 32'h0);
    end
    $display("test interrupts done");
    conclude();
  end

  initial
  begin
    repeat (100000) @(posedge aclk);
    n_mismatch++;
    conclude();
  end
endmodule : sba_arbiter_tb
`default_nettype wire
